/* hw/tic_top.v */
// time interval counter: timebase chain, interval counter, ahb-lite registers
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "tic_defs.vh"
// register map, byte address = 4 * index, each register in the low byte of its word:
//   a1 control: b0 timebase enable, b1 count enable, b2 match flag,
//      b3 single shot, b5:4 timebase select, b6 stored, b7 reads zero
//   a2 subseconds, a3 seconds, a4 minutes, a5 hours (loadable while b0 is low)
//   a6 compare value
//   a7 interrupt status (b0 match, cleared by a read)
//   a8 interrupt mask (b0)
//   a9 interval count (read only)
// unmapped indices read zero and ignore writes; every answer is okay with no wait.
// irq_o and wake_o are levels, and like every output they leave a flop.
// the design runs entirely on the core clock; the crystal rate is recreated by a
// prescaler so the block keeps one clock domain; only powerdown_i passes a two-flop synchroniser.
module tic_top #(
    parameter TICK_CYCLES = `TIC_TICK_NS / `TIC_CLK_NS
) (
    input  wire        core_clk_i,
    input  wire        reset_n_i,
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    input  wire        powerdown_i,
    output reg  [31:0] hrdata_o,
    output reg         hreadyout_o,
    output reg         hresp_o,
    output reg         irq_o,
    output reg         wake_o
);

    // bus decode and register state
    // an access is taken only with hready high, so a stalled bus never
    // captures the same address phase twice
    reg        wr_pend_r;
    reg  [7:0] wr_idx_r;
    reg  [7:0] ctrl_r;
    reg  [7:0] compare_r;
    reg        irq_stat_r;
    reg        irq_mask_r;
    reg  [7:0] icount_r;
    reg  [7:0] icount_nxt;
    reg  [31:0] prescale_r;
    reg        tick_r;
    reg        pd_meta_r;
    reg        pd_sync_r;
    reg  [31:0] rdata_nxt;

    wire        access = hsel_i && hready_i &&
                         (htrans_i == `TIC_HTRANS_NONSEQ || htrans_i == `TIC_HTRANS_SEQ);
    wire [7:0]  req_idx = haddr_i[`TIC_ADDR_IDX_HI:`TIC_ADDR_IDX_LO];
    wire        rd_acc  = access && !hwrite_i;
    wire [7:0]  wbyte   = hwdata_i[7:0];
    wire        wr_ctrl = wr_pend_r && (wr_idx_r == `TIC_IDX_CTRL);
    wire        wr_compare = wr_pend_r && (wr_idx_r == `TIC_IDX_COMPARE);
    wire        wr_mask    = wr_pend_r && (wr_idx_r == `TIC_IDX_IRQ_MASK);
    wire        rd_status  = rd_acc && (req_idx == `TIC_IDX_IRQ_STAT);
    // control fields as the rest of the logic uses them
    wire        timebase_clock_enable    = ctrl_r[`TIC_CTRL_TIMEBASE_CLOCK_ENABLE];
    wire        interval_count_enable    = ctrl_r[`TIC_CTRL_INTERVAL_COUNT_ENABLE];
    wire [1:0]  sel     = ctrl_r[`TIC_CTRL_SEL_HI:`TIC_CTRL_SEL_LO];

    // timebase chain
    // subseconds, seconds, minutes, hours; a stage only loads while the chain
    // is stopped, so software never races a carry when setting the time
    wire [7:0] tb_count [0:`TIC_STAGES-1];
    wire [`TIC_STAGES-1:0] tb_wrap;
    // only a falling timebase enable clears the chain; writing zero while it is
    // already stopped keeps any time that software has just loaded
    wire       tb_clear = wr_ctrl && timebase_clock_enable && !wbyte[`TIC_CTRL_TIMEBASE_CLOCK_ENABLE];

    // each stage steps on the carry of the one below; stage 0 on the tick
    genvar g;
    generate
        for (g = 0; g < `TIC_STAGES; g = g + 1) begin : g_stage
            wire [7:0] max_v  = (g == 0) ? `TIC_MAX_SUBSEC :
                                (g == 1) ? `TIC_MAX_SEC :
                                (g == 2) ? `TIC_MAX_MIN : `TIC_MAX_HOUR;
            wire       step_v = (g == 0) ? (timebase_clock_enable && tick_r) : tb_wrap[(g == 0) ? 0 : g - 1];
            // software load addresses the stage by its index
            wire       load_v = wr_pend_r && !timebase_clock_enable &&
                                (wr_idx_r == `TIC_IDX_SUBSEC + g);
            tic_wrap_cnt u_cnt (
                .core_clk_i  (core_clk_i),
                .reset_n_i   (reset_n_i),
                .clear_i     (tb_clear),
                .load_i      (load_v),
                .load_data_i (wbyte),
                .step_i      (step_v),
                .max_i       (max_v),
                .count_o     (tb_count[g]),
                .wrap_o      (tb_wrap[g])
            );
        end
    endgenerate

    // crystal-rate tick
    // the prescaler is free running so a stopped timebase resumes on a fixed
    // phase; it never stops for power-down, which only gates the core
    wire prescale_end = (prescale_r == TICK_CYCLES - 1);

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prescale_r <= `TIC_WORD_RESET;
        end else if (prescale_end) begin
            prescale_r <= `TIC_WORD_RESET;
        end else begin
            prescale_r <= prescale_r + 32'h00000001;
        end
    end

    // one-cycle tick, registered so the timebase sees a clean single pulse
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= prescale_end;
        end
    end

    // interval counter
    // the selected stage's own step is the step (the tick, or the carry of the stage below); minutes and hours are reached
    // through the carries of the stages below, so no divider is duplicated
    reg overflow;
    always @* begin
        case (sel)
            `TIC_SEL_SUBSEC: overflow = timebase_clock_enable && tick_r;
            `TIC_SEL_SEC:    overflow = tb_wrap[0];
            `TIC_SEL_MIN:    overflow = tb_wrap[1];
            `TIC_SEL_HOUR:   overflow = tb_wrap[2];
            default:         overflow = 1'b0;
        endcase
    end

    // the match compares the incremented value so the flag rises on the same
    // edge that the count reaches compare; compare zero takes a full wrap
    wire       step_ic = interval_count_enable && overflow;
    wire [7:0] ic_inc  = icount_r + 8'h01;
    wire       hit     = step_ic && (ic_inc == compare_r);

    // next count: zero when disabled, reload to zero on a timeout;
    // single shot also drops the enable, so the count then stays at zero
    always @* begin
        if (!interval_count_enable) begin
            icount_nxt = `TIC_BYTE_RESET;
        end else if (hit) begin
            icount_nxt = `TIC_BYTE_RESET;
        end else if (step_ic) begin
            icount_nxt = ic_inc;
        end else begin
            icount_nxt = icount_r;
        end
    end

    // count register; clearing the enable zeroes it one edge after the write
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            icount_r <= `TIC_BYTE_RESET;
        end else begin
            icount_r <= icount_nxt;
        end
    end

    // control register
    // a hardware match wins over a software clear written in the same cycle,
    // so a timeout is never lost; the top bit is not stored and reads zero
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= `TIC_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {1'b0, wbyte[`TIC_CTRL_RSVD6:0]};
            end
            if (hit) begin
                ctrl_r[`TIC_CTRL_MATCH] <= 1'b1;
                if (ctrl_r[`TIC_CTRL_SSHOT]) begin
                    ctrl_r[`TIC_CTRL_INTERVAL_COUNT_ENABLE] <= 1'b0;
                end
            end
        end
    end

    // compare value, written whole; no field of it is reserved
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            compare_r <= `TIC_BYTE_RESET;
        end else if (wr_compare) begin
            compare_r <= wbyte;
        end
    end

    // interrupt status
    // read clears the sticky bit, but a match in that cycle survives
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_r <= `TIC_IRQ_RESET;
        end else if (hit) begin
            irq_stat_r <= 1'b1;
        end else if (rd_status) begin
            irq_stat_r <= 1'b0;
        end
    end

    // interrupt mask; masking hides the request but keeps the status
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_mask_r <= `TIC_IRQ_RESET;
        end else if (wr_mask) begin
            irq_mask_r <= wbyte[`TIC_IRQ_MATCH];
        end
    end

    // powerdown comes from the power controller, outside this logic; two
    // flops keep a metastable level away from the wake decision
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_meta_r <= 1'b0;
            pd_sync_r <= 1'b0;
        end else begin
            pd_meta_r <= powerdown_i;
            pd_sync_r <= pd_meta_r;
        end
    end

    // interrupt request, a level one cycle behind the status bit
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_stat_r && irq_mask_r;
        end
    end

    // wake request; it holds until the status or the mask clears or power-down ends, and it only
    // follows power-down after the two-stage synchroniser and its own flop, three edges late
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= irq_stat_r && irq_mask_r && pd_sync_r;
        end
    end

    // ahb-lite slave: read multiplexer
    // every bit above a register's width, and every unmapped index, reads zero
    always @* begin
        rdata_nxt = `TIC_WORD_RESET;
        case (req_idx)
            `TIC_IDX_CTRL:     rdata_nxt[7:0] = ctrl_r;
            `TIC_IDX_SUBSEC:   rdata_nxt[7:0] = tb_count[0];
            `TIC_IDX_SEC:      rdata_nxt[7:0] = tb_count[1];
            `TIC_IDX_MIN:      rdata_nxt[7:0] = tb_count[2];
            `TIC_IDX_HOUR:     rdata_nxt[7:0] = tb_count[3];
            `TIC_IDX_COMPARE:  rdata_nxt[7:0] = compare_r;
            `TIC_IDX_IRQ_STAT: rdata_nxt[0]   = irq_stat_r;
            `TIC_IDX_IRQ_MASK: rdata_nxt[0]   = irq_mask_r;
            `TIC_IDX_COUNT:    rdata_nxt[7:0] = icount_r;
            default:           rdata_nxt      = `TIC_WORD_RESET;
        endcase
    end

    // write address capture: written data arrive one cycle after their
    // address, so the index is held for the data phase edge
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= `TIC_BYTE_RESET;
        end else begin
            wr_pend_r <= access && hwrite_i;
            wr_idx_r  <= req_idx;
        end
    end

    // read data are sampled at the address phase edge and stand through the
    // data phase; a read right behind a write to the same register sees the
    // old value, a limitation that software must allow for
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o <= `TIC_WORD_RESET;
        end else if (rd_acc) begin
            hrdata_o <= rdata_nxt;
        end
    end

    // zero wait states and no error answers; held in flops so that every
    // output leaves a register
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= `TIC_HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= `TIC_HRESP_OKAY;
        end
    end

    // hsize is not checked: only whole-word transfers are used
    // the reduction only gives the port a reader
    wire unused_ok = |hsize_i;
endmodule

/* hw/tic_wrap_cnt.v */
// one wrapping timebase stage with clear, software load and carry out
`timescale 1ns/100ps
module tic_wrap_cnt (
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    input  wire       clear_i,
    input  wire       load_i,
    input  wire [7:0] load_data_i,
    input  wire       step_i,
    input  wire [7:0] max_i,
    output wire [7:0] count_o,
    output wire       wrap_o
);
`include "tic_defs.vh"

    reg  [7:0] count_r;
    wire [7:0] count_nxt;

    // carry fires on the step that rolls the stage back to zero
    assign wrap_o    = step_i && (count_r == max_i);
    assign count_nxt = wrap_o ? `TIC_BYTE_RESET : count_r + 8'h01;
    assign count_o   = count_r;

    // clear beats load beats step; a disabled timebase holds its value until software loads it
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= `TIC_BYTE_RESET;
        end else if (clear_i) begin
            count_r <= `TIC_BYTE_RESET;
        end else if (load_i) begin
            count_r <= load_data_i;
        end else if (step_i) begin
            count_r <= count_nxt;
        end
    end
endmodule

/* inc/tic_defs.vh */
// constants of the time interval counter: register map, fields, resets, timing
// Notes on behaviour
// - timeouts range from one 1/128 second step up to 255 hour steps; compare zero gives 256 here.
// - the counter runs from a slow crystal-rate tick, independent of core power-down.
// - the interval counter steps on each overflow of the timebase stage picked by select.
// - when the interval counter equals the compare value the match flag (control bit 2) is set.
// - the match raises an interrupt only while its enable (mask) bit is set.
// - with the interrupt enabled in power-down a match asserts the wake request.
// - software may preload the timebase registers with the time of day.
// - six registers exist; control sits at index a1 and resets to zero; the code maps nine, a1 to a9.
// - select 00 is 1/128 s, 01 seconds, 10 minutes, 11 hours.
// - single-shot mode clears the count enable on a timeout, else the counter reloads.
// - count enable runs the interval counter; clearing it stops and zeroes it.
// - clock enable runs the timebase; clearing it stops and clears it, then it is writable.
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH

// register indices; byte address is four times the index
`define TIC_IDX_CTRL      8'ha1
`define TIC_IDX_SUBSEC    8'ha2
`define TIC_IDX_SEC       8'ha3
`define TIC_IDX_MIN       8'ha4
`define TIC_IDX_HOUR      8'ha5
`define TIC_IDX_COMPARE   8'ha6
`define TIC_IDX_IRQ_STAT  8'ha7
`define TIC_IDX_IRQ_MASK  8'ha8
`define TIC_IDX_COUNT     8'ha9
`define TIC_ADDR_IDX_HI   9
`define TIC_ADDR_IDX_LO   2

// control fields
`define TIC_CTRL_RESET    8'h00
`define TIC_CTRL_TIMEBASE_CLOCK_ENABLE     0
`define TIC_CTRL_INTERVAL_COUNT_ENABLE     1
`define TIC_CTRL_MATCH    2
`define TIC_CTRL_SSHOT    3
`define TIC_CTRL_SEL_LO   4
`define TIC_CTRL_SEL_HI   5
`define TIC_CTRL_RSVD6    6
`define TIC_SEL_SUBSEC    2'h0
`define TIC_SEL_SEC       2'h1
`define TIC_SEL_MIN       2'h2
`define TIC_SEL_HOUR      2'h3

// interrupt status / mask layout
`define TIC_IRQ_MATCH     0
`define TIC_IRQ_RESET     1'b0

// timebase limits
`define TIC_MAX_SUBSEC    8'h7f
`define TIC_MAX_SEC       8'h3b
`define TIC_MAX_MIN       8'h3b
`define TIC_MAX_HOUR      8'h17
`define TIC_STAGES        4
`define TIC_BYTE_RESET    8'h00

// timing: one 1/128 second tick at the core clock rate
`define TIC_TICK_NS       7812500
`define TIC_CLK_NS        20

// ahb encodings
`define TIC_HTRANS_NONSEQ 2'h2
`define TIC_HTRANS_SEQ    2'h3
`define TIC_HRESP_OKAY    1'b0
`define TIC_WORD_RESET    32'h00000000

`endif

/* testbench/test_time_interval_counter.sv */
// self-checking bench for the time interval counter
`timescale 1ns/100ps
`include "tic_defs.vh"
module test_time_interval_counter;
    logic        core_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic        powerdown_i = 1'b0;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] q;
    wire  [31:0] hrdata_o;
    wire         hreadyout_o, hresp_o, irq_o, wake_o;
    integer      error_cnt = 0;
    integer      check_count = 0;
    // a four-cycle tick keeps every timeout but the 255-step one within a few dozen cycles
    tic_top #(.TICK_CYCLES(4)) i_dut (
        .core_clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .powerdown_i, .hrdata_o, .hreadyout_o, .hresp_o,
        .irq_o, .wake_o);
    always #10 core_clk_i = ~core_clk_i;
    task final_report;
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count = check_count + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // wait for hready (0), irq (1) or wake (2); a spent bound ends the run
    task wt(input integer k);
        integer n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n = n + 1;
        end while ((k == 0 ? hreadyout_o : k == 1 ? irq_o : wake_o) !== 1'b1 && n < 200);
        if (n >= 200) begin
            error_cnt = error_cnt + 1;
            final_report;
        end
    endtask
    // single word transfer; read data is taken at the edge that ends the data phase
    task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        haddr_i <= {22'h0, i, 2'h0};
        htrans_i <= `TIC_HTRANS_NONSEQ;
        hwrite_i <= w;
        hsel_i <= 1'b1;
        wt(0);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        wt(0);
        q = hrdata_o;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task rc(input string n, input logic [7:0] i, input logic [31:0] e);
        xfer(1'b0, i, 8'h0);
        chk(n, q, e);
        chk("hresp", {31'h0, hresp_o}, 32'h0);
    endtask
    task t_reset;
        rc("control", 8'ha1, 32'h0);
        wr(8'hb0, 8'hff);
        rc("unmapped", 8'hb0, 32'h0);
    endtask
    // every stage at its top value so one tick ripples through all of them
    task t_timebase;
        wr(8'ha2, 8'h7f);
        wr(8'ha3, 8'h3b);
        wr(8'ha4, 8'h3b);
        wr(8'ha5, 8'h17);
        rc("subsec", 8'ha2, 32'h7f);
        wr(8'ha1, 8'h01);
        repeat (20) @(posedge core_clk_i);
        rc("hour", 8'ha5, 32'h0);
        rc("minute", 8'ha4, 32'h0);
        wr(8'ha1, 8'h00);
        rc("subsec", 8'ha2, 32'h0);
    endtask
    task t_count;
        wr(8'ha2, 8'h7e);
        wr(8'ha1, 8'h13);
        repeat (20) @(posedge core_clk_i);
        rc("count", `TIC_IDX_COUNT, 32'h1);
        wr(8'ha1, 8'h11);
        // the count clears one edge after the write lands
        @(posedge core_clk_i);
        rc("count", `TIC_IDX_COUNT, 32'h0);
        wr(8'ha1, 8'h00);
    endtask
    task t_match;
        wr(`TIC_IDX_IRQ_MASK, 8'h01);
        wr(8'ha6, 8'h03);
        wr(8'ha1, 8'h0b);
        wt(1);
        rc("control", 8'ha1, 32'h0d);
        rc("count", `TIC_IDX_COUNT, 32'h0);
        rc("status", `TIC_IDX_IRQ_STAT, 32'h1);
        rc("status", `TIC_IDX_IRQ_STAT, 32'h0);
        chk("irq", {31'h0, irq_o}, 32'h0);
        rc("control", 8'ha1, 32'h0d);
        wr(8'ha1, 8'h00);
    endtask
    // only the stages below the selected one are primed to overflow
    task t_select;
        for (int s = 1; s < 4; s++) begin
            wr(8'ha2, 8'h7f);
            if (s > 1) wr(8'ha3, 8'h3b);
            if (s > 2) wr(8'ha4, 8'h3b);
            wr(8'ha6, 8'h01);
            wr(8'ha1, {2'h0, s[1:0], 4'hb});
            wt(1);
            rc("control", 8'ha1, {26'h0, s[1:0], 4'hd});
            rc("status", `TIC_IDX_IRQ_STAT, 32'h1);
            wr(8'ha1, 8'h00);
        end
    endtask
    task t_mask;
        wr(`TIC_IDX_IRQ_MASK, 8'h00);
        wr(8'ha1, 8'h03);
        repeat (40) @(posedge core_clk_i);
        chk("irq", {31'h0, irq_o}, 32'h0);
        rc("control", 8'ha1, 32'h07);
        powerdown_i <= 1'b1;
        wr(`TIC_IDX_IRQ_MASK, 8'h01);
        wt(2);
        chk("irq", {31'h0, irq_o}, 32'h1);
        powerdown_i <= 1'b0;
        wr(8'ha1, 8'h00);
        rc("status", `TIC_IDX_IRQ_STAT, 32'h1);
    endtask
    // full-range single shot of 255 steps, run with the core in power-down throughout
    task t_range;
        wr(8'ha6, 8'hff);
        powerdown_i <= 1'b1;
        wr(8'ha1, 8'h0b);
        repeat (1000) @(posedge core_clk_i);
        chk("irq early", {31'h0, irq_o}, 32'h0);
        wt(1);
        chk("wake", {31'h0, wake_o}, 32'h1);
        powerdown_i <= 1'b0;
        rc("status", `TIC_IDX_IRQ_STAT, 32'h1);
        wr(8'ha1, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset;
        t_timebase;
        t_count;
        t_match;
        t_select;
        t_mask;
        t_range;
        final_report;
    end
endmodule

/* testbench/tic_assertions.sv */
// port checker for the time interval counter, bound into the top module
`timescale 1ns/100ps
`include "tic_defs.vh"
module tic_assertions (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic        powerdown_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic        irq_o,
    input  wire logic        wake_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // address phase decode as the slave sees it
    wire       take = hsel_i && hready_i && htrans_i[1];
    wire       rd   = take && !hwrite_i;
    wire [7:0] idx  = haddr_i[9:2];
    reg        wr_r;
    reg  [7:0] wr_idx_r;
    reg        mask_r;
    // shadow of the irq mask; write data only lands one cycle after its address
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_r     <= 1'b0;
            wr_idx_r <= 8'h00;
            mask_r   <= 1'b0;
        end else begin
            wr_r     <= take && hwrite_i;
            wr_idx_r <= idx;
            if (wr_r && wr_idx_r == `TIC_IDX_IRQ_MASK) begin
                mask_r <= hwdata_i[0];
            end
        end
    end
    a_bus_okay: assert property (take |=> hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    a_unmapped_zero: assert property (
        rd && (idx < 8'ha1 || idx > 8'ha9) |=> hrdata_o == 32'h0) else $error("unmapped not zero");
    a_ctrl_width: assert property (
        rd && idx == `TIC_IDX_CTRL |=> hrdata_o[31:7] == 25'h0) else $error("control too wide");
    a_subsec_range: assert property (
        rd && idx == 8'ha2 |=> hrdata_o <= 32'h7f) else $error("subseconds out of range");
    a_time_range: assert property (
        rd && (idx == 8'ha3 || idx == 8'ha4) |=> hrdata_o <= 32'h3b) else $error("time out of range");
    a_irq_masked: assert property (irq_o |-> $past(mask_r))
        else $error("irq while masked");
    a_status_clear: assert property (
        rd && idx == `TIC_IDX_IRQ_STAT |-> ##[2:3] !irq_o) else $error("irq kept after status read");
    a_wake_irq: assert property (wake_o |-> irq_o)
        else $error("wake without irq");
    a_wake_pd: assert property ($rose(wake_o) |->
        $past(powerdown_i, 2) || $past(powerdown_i, 3) || $past(powerdown_i, 4))
        else $error("wake without power-down");
    a_wake_drop: assert property (!powerdown_i [*5] |-> !wake_o)
        else $error("wake held while running");
endmodule
bind tic_top tic_assertions u_tic_chk (
    .core_clk_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .powerdown_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_o, .wake_o);
